// ===== verilog/ohci_cmd_pkg.sv
package ohci_cmd_pkg;

  // ************************************************************
  // Register map and field layout
  // ************************************************************
  localparam int unsigned CSR_ADDR_W     = 12;
  localparam logic [11:0] CONTROL_OFF    = 12'h004;
  localparam logic [11:0] CMD_STATUS_OFF = 12'h008;
  localparam logic [31:0] CMD_STATUS_RST = 32'h0000_0000;
  localparam int unsigned CS_HCR_BIT     = 0;
  localparam int unsigned CS_CLF_BIT     = 1;
  localparam int unsigned CS_BLF_BIT     = 2;
  localparam int unsigned CS_OCR_BIT     = 3;
  localparam int unsigned CS_SOC_LSB     = 16;
  localparam int unsigned CTL_FS_LSB     = 6;
  localparam int unsigned CTL_IR_BIT     = 8;
  localparam logic        CTL_IR_RST     = 1'h0;
  localparam int unsigned IS_SO_BIT      = 0;
  localparam int unsigned IS_OC_BIT      = 30;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_PERIOD_PS     = 4000;
  localparam int unsigned SOFT_RESET_MAX_NS = 10000;
  // Longest time, so rounded down
  localparam int unsigned SR_CYCLES_DEF = (SOFT_RESET_MAX_NS * 1000) / CLK_PERIOD_PS;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    FS_RESET       = 2'h0,
    FS_RESUME      = 2'h1,
    FS_OPERATIONAL = 2'h2,
    FS_SUSPEND     = 2'h3
  } func_state_e;

  typedef enum logic [1:0] {
    SEL_NONE = 2'h0,
    SEL_CTRL = 2'h1,
    SEL_CS   = 2'h2
  } reg_sel_e;

  // Events from the list-processing engine
  typedef struct packed {
    logic bulk_start;
    logic bulk_td_found;
    logic ctrl_start;
    logic ctrl_td_found;
    logic overrun;
    logic owner_done;
  } list_evt_s;

  // Go or skip answers to the list-processing engine
  typedef struct packed {
    logic bulk_go;
    logic bulk_skip;
    logic ctrl_go;
    logic ctrl_skip;
  } list_cmd_s;

endpackage : ohci_cmd_pkg

// ===== verilog/ohci_command_status_logic.sv
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module ohci_command_status_logic
  import ohci_cmd_pkg::*;
#(
  parameter int unsigned SOFT_RESET_CYCLES = SR_CYCLES_DEF
)
(
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_b_i,
  input  wire logic [CSR_ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic                  s_axi_awvalid_i,
  output logic                       s_axi_awready_o,
  input  wire logic [31:0]           s_axi_wdata_i,
  input  wire logic [3:0]            s_axi_wstrb_i,
  input  wire logic                  s_axi_wvalid_i,
  output logic                       s_axi_wready_o,
  output logic [1:0]                 s_axi_bresp_o,
  output logic                       s_axi_bvalid_o,
  input  wire logic                  s_axi_bready_i,
  input  wire logic [CSR_ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic                  s_axi_arvalid_i,
  output logic                       s_axi_arready_o,
  output logic [31:0]                s_axi_rdata_o,
  output logic [1:0]                 s_axi_rresp_o,
  output logic                       s_axi_rvalid_o,
  input  wire logic                  s_axi_rready_i,
  input  wire list_evt_s             list_evt_i,
  output list_cmd_s                  list_cmd_o,
  output logic [31:0]                int_status_set_o,
  output logic [1:0]                 functional_state_o,
  output logic                       interrupt_routing_o,
  output logic                       soft_reset_busy_o,
  output logic                       root_hub_reset_o
);

  localparam int unsigned SR_CNT_W = $clog2(SOFT_RESET_CYCLES + 1);

  // ************************************************************
  // Decode helpers
  // ************************************************************
  // Word-aligned compare; byte offset bits are ignored
  function automatic reg_sel_e decode_sel(input logic [CSR_ADDR_W-1:0] addr);
    reg_sel_e sel;
    sel = SEL_NONE;
    if (addr[CSR_ADDR_W-1:2] == CMD_STATUS_OFF[CSR_ADDR_W-1:2])
      sel = SEL_CS;
    else if (addr[CSR_ADDR_W-1:2] == CONTROL_OFF[CSR_ADDR_W-1:2])
      sel = SEL_CTRL;
    return sel;
  endfunction : decode_sel

  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0;
    for (int i = 0; i < 4; i++)
      m[i*8 +: 8] = {8{strb[i]}};
    return m;
  endfunction : strb_mask

  // ************************************************************
  // AXI4-Lite write path
  // ************************************************************
  logic                  aw_held_r;
  logic                  w_held_r;
  logic                  bvalid_r;
  logic [1:0]            bresp_r;
  logic [CSR_ADDR_W-1:0] aw_addr_r;
  logic [31:0]           wdata_r;
  logic [3:0]            wstrb_r;
  reg_sel_e              wr_sel;
  logic                  wr_go;
  logic [31:0]           wmask;

  // Address and data are caught independently, in either order
  assign s_axi_awready_o = ~aw_held_r;
  assign s_axi_wready_o  = ~w_held_r;
  assign wr_go  = aw_held_r & w_held_r & ~bvalid_r;
  assign wr_sel = decode_sel(aw_addr_r);
  assign wmask  = strb_mask(wstrb_r);
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o  = bresp_r;

  // Write address holding register
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
    end
    else if (s_axi_awvalid_i && !aw_held_r)
    begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr_i;
    end
    else if (wr_go)
      aw_held_r <= 1'b0;
  end

  // Write data holding register
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      w_held_r <= 1'b0;
      wdata_r  <= 32'h0;
      wstrb_r  <= 4'h0;
    end
    else if (s_axi_wvalid_i && !w_held_r)
    begin
      w_held_r <= 1'b1;
      wdata_r  <= s_axi_wdata_i;
      wstrb_r  <= s_axi_wstrb_i;
    end
    else if (wr_go)
      w_held_r <= 1'b0;
  end

  // Response; unmapped addresses answer SLVERR and change nothing
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_bready_i)
      bvalid_r <= 1'b0;
  end

  // ************************************************************
  // Command status and control state
  // ************************************************************
  logic                hcr_r;
  logic                clf_r;
  logic                blf_r;
  logic                ocr_r;
  logic [1:0]          soc_r;
  logic [SR_CNT_W-1:0] sr_cnt_r;
  func_state_e         fstate_r;
  logic                ir_r;
  logic                rh_rst_r;
  logic                cs_wr;
  logic                ctl_wr;
  logic [31:0]         sw_set;
  logic                sr_last;
  logic                ovr_hit;
  logic                oc_hit;
  logic                hcr_nxt;
  logic                clf_nxt;
  logic                blf_nxt;
  logic                ocr_nxt;
  logic [1:0]          soc_nxt;
  logic [SR_CNT_W-1:0] sr_cnt_nxt;
  func_state_e         fstate_nxt;
  logic                ir_nxt;
  logic [31:0]         is_set_nxt;
  list_cmd_s           cmd_nxt;
  list_cmd_s           cmd_r;
  logic [31:0]         is_set_r;

  assign cs_wr  = wr_go & (wr_sel == SEL_CS);
  assign ctl_wr = wr_go & (wr_sel == SEL_CTRL);
  // Write-one-to-set: zeros in the data simply contribute nothing
  assign sw_set = cs_wr ? (wdata_r & wmask) : 32'h0;

  // Soft reset runs for a fixed count, then clears its own bit
  assign sr_last    = hcr_r & (sr_cnt_r == SR_CNT_W'(SOFT_RESET_CYCLES - 1));
  assign sr_cnt_nxt = (hcr_r && !sr_last) ? sr_cnt_r + 1'b1 : '0;
  // A fresh request on the finishing edge wins and restarts the reset
  assign hcr_nxt    = sw_set[CS_HCR_BIT] | (hcr_r & ~sr_last);

  // List filled bits: set by software or a found descriptor wins over clear
  assign clf_nxt = ~hcr_r & (sw_set[CS_CLF_BIT] | list_evt_i.ctrl_td_found
                   | (clf_r & ~list_evt_i.ctrl_start));
  assign blf_nxt = ~hcr_r & (sw_set[CS_BLF_BIT] | list_evt_i.bulk_td_found
                   | (blf_r & ~list_evt_i.bulk_start));

  // Ownership request holds until the changeover completes
  assign ocr_nxt = ~hcr_r & (sw_set[CS_OCR_BIT] | (ocr_r & ~list_evt_i.owner_done));
  assign oc_hit  = ocr_nxt & ~ocr_r;

  // Overrun counts regardless of the status flag, wrapping at 3
  assign ovr_hit = list_evt_i.overrun & ~hcr_r;
  assign soc_nxt = hcr_r ? 2'h0 : soc_r + 2'(ovr_hit);

  // Suspended while a soft reset runs; routing is left untouched by it
  assign fstate_nxt = hcr_r ? FS_SUSPEND :
                      (ctl_wr && wmask[CTL_FS_LSB]) ?
                      func_state_e'(wdata_r[CTL_FS_LSB +: 2]) : fstate_r;
  assign ir_nxt = (ctl_wr && wmask[CTL_IR_BIT]) ? wdata_r[CTL_IR_BIT] : ir_r;

  assign is_set_nxt = (32'(ovr_hit) << IS_SO_BIT) | (32'(oc_hit) << IS_OC_BIT);

  // Go or skip at each list head, judged on the bit before it clears
  assign cmd_nxt.bulk_go   = list_evt_i.bulk_start & blf_r & ~hcr_r;
  assign cmd_nxt.bulk_skip = list_evt_i.bulk_start & ~(blf_r & ~hcr_r);
  assign cmd_nxt.ctrl_go   = list_evt_i.ctrl_start & clf_r & ~hcr_r;
  assign cmd_nxt.ctrl_skip = list_evt_i.ctrl_start & ~(clf_r & ~hcr_r);

  // Command status bits
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      hcr_r    <= CMD_STATUS_RST[CS_HCR_BIT];
      clf_r    <= CMD_STATUS_RST[CS_CLF_BIT];
      blf_r    <= CMD_STATUS_RST[CS_BLF_BIT];
      ocr_r    <= CMD_STATUS_RST[CS_OCR_BIT];
      soc_r    <= CMD_STATUS_RST[CS_SOC_LSB +: 2];
      sr_cnt_r <= '0;
    end
    else
    begin
      hcr_r    <= hcr_nxt;
      clf_r    <= clf_nxt;
      blf_r    <= blf_nxt;
      ocr_r    <= ocr_nxt;
      soc_r    <= soc_nxt;
      sr_cnt_r <= sr_cnt_nxt;
    end
  end

  // Control state; hardware reset picks the reset state, routing cleared
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      fstate_r <= FS_RESET;
      ir_r     <= CTL_IR_RST;
    end
    else
    begin
      fstate_r <= fstate_nxt;
      ir_r     <= ir_nxt;
    end
  end

  // Registered event outputs; root hub reset follows hardware reset only
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cmd_r    <= '0;
      is_set_r <= 32'h0;
      rh_rst_r <= 1'b1;
    end
    else
    begin
      cmd_r    <= cmd_nxt;
      is_set_r <= is_set_nxt;
      rh_rst_r <= 1'b0;
    end
  end

  assign list_cmd_o          = cmd_r;
  assign int_status_set_o    = is_set_r;
  assign functional_state_o  = fstate_r;
  assign interrupt_routing_o = ir_r;
  assign soft_reset_busy_o   = hcr_r;
  assign root_hub_reset_o    = rh_rst_r;

  // ************************************************************
  // AXI4-Lite read path
  // ************************************************************
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  reg_sel_e    rd_sel;
  logic [31:0] cs_val;
  logic [31:0] ctl_val;
  logic [31:0] rd_mux;

  // Reserved bits read as zero
  assign cs_val  = (32'(soc_r) << CS_SOC_LSB) | (32'(ocr_r) << CS_OCR_BIT)
                 | (32'(blf_r) << CS_BLF_BIT) | (32'(clf_r) << CS_CLF_BIT)
                 | (32'(hcr_r) << CS_HCR_BIT);
  assign ctl_val = (32'(fstate_r) << CTL_FS_LSB) | (32'(ir_r) << CTL_IR_BIT);
  assign rd_sel  = decode_sel(s_axi_araddr_i);
  assign rd_mux  = (rd_sel == SEL_CS) ? cs_val : (rd_sel == SEL_CTRL) ? ctl_val : 32'h0;
  assign s_axi_arready_o = ~rvalid_r;
  assign s_axi_rvalid_o  = rvalid_r;
  assign s_axi_rdata_o   = rdata_r;
  assign s_axi_rresp_o   = rresp_r;

  // Data is captured at the address edge so it cannot shift while waiting
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
      rresp_r  <= RESP_OKAY;
    end
    else if (s_axi_arvalid_i && !rvalid_r)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_rready_i)
      rvalid_r <= 1'b0;
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  w1s_set_a: assert property (cs_wr && wmask[CS_CLF_BIT] && wdata_r[CS_CLF_BIT] && !hcr_r
    |=> clf_r) else $error("control list filled not set by write");
  w0_keep_a: assert property (cs_wr && !hcr_r && blf_r && !list_evt_i.bulk_start
    |=> blf_r) else $error("bulk list filled lost on write");
  read_value_a: assert property (s_axi_arvalid_i && s_axi_arready_o && rd_sel == SEL_CS
    |=> s_axi_rvalid_o && s_axi_rdata_o == $past(cs_val)) else $error("bad read data");
  overrun_count_a: assert property (ovr_hit
    |=> soc_r == 2'($past(soc_r) + 2'h1) && int_status_set_o[IS_SO_BIT])
    else $error("overrun count or flag wrong");
  owner_flag_a: assert property (!ocr_r ##1 ocr_r
    |-> int_status_set_o[IS_OC_BIT]) else $error("ownership flag missing");
  owner_hold_a: assert property (ocr_r && !list_evt_i.owner_done && !hcr_r
    |=> ocr_r) else $error("ownership request dropped early");
  bulk_head_a: assert property (list_evt_i.bulk_start && !hcr_r
    |=> list_cmd_o.bulk_go == $past(blf_r) && list_cmd_o.bulk_skip == !$past(blf_r))
    else $error("bulk go or skip wrong");
  bulk_clear_a: assert property (list_evt_i.bulk_start && !list_evt_i.bulk_td_found
    && !sw_set[CS_BLF_BIT] |=> !blf_r) else $error("bulk list filled not cleared");
  ctrl_head_a: assert property (list_evt_i.ctrl_start && !hcr_r
    |=> list_cmd_o.ctrl_go == $past(clf_r) && list_cmd_o.ctrl_skip == !$past(clf_r))
    else $error("control go or skip wrong");
  ctrl_refill_a: assert property (list_evt_i.ctrl_td_found && !hcr_r
    |=> clf_r) else $error("control list filled not refilled");
  sr_bound_a: assert property (sr_cnt_r < SR_CNT_W'(SOFT_RESET_CYCLES))
    else $error("soft reset overran its limit");
  sr_end_a: assert property (sr_last && !sw_set[CS_HCR_BIT]
    |=> !hcr_r && functional_state_o == FS_SUSPEND) else $error("soft reset end wrong");
  sr_route_a: assert property (hcr_r && !ctl_wr
    |=> interrupt_routing_o == $past(ir_r)) else $error("routing changed by reset");
  sr_bus_a: assert property (hcr_r |-> soft_reset_busy_o && !root_hub_reset_o)
    else $error("bus not held or hub reset");

  wrap_c: cover property (soc_r == 2'h3 && ovr_hit);
  sr_done_c: cover property (sr_last);
  bulk_go_c: cover property (list_cmd_o.bulk_go);
  owner_c: cover property (ocr_r && list_evt_i.owner_done);

endmodule : ohci_command_status_logic
`default_nettype wire

// ===== testbench/host_driver_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Driver-side register bus master
// ****************************************************************
module host_driver_model
  import ohci_cmd_pkg::*;
(
  input  wire logic                  core_clk_i,
  output logic [CSR_ADDR_W-1:0]      awaddr_o,
  output logic                       awvalid_o,
  input  wire logic                  awready_i,
  output logic [31:0]                wdata_o,
  output logic [3:0]                 wstrb_o,
  output logic                       wvalid_o,
  input  wire logic                  wready_i,
  input  wire logic [1:0]            bresp_i,
  input  wire logic                  bvalid_i,
  output logic                       bready_o,
  output logic [CSR_ADDR_W-1:0]      araddr_o,
  output logic                       arvalid_o,
  input  wire logic                  arready_i,
  input  wire logic [31:0]           rdata_i,
  input  wire logic [1:0]            rresp_i,
  input  wire logic                  rvalid_i,
  output logic                       rready_o
);
  // Bus idle at time zero
  initial
  begin
    awaddr_o  = '0;
    awvalid_o = 1'b0;
    wdata_o   = '0;
    wstrb_o   = 4'h0;
    wvalid_o  = 1'b0;
    bready_o  = 1'b0;
    araddr_o  = '0;
    arvalid_o = 1'b0;
    rready_o  = 1'b0;
  end

  // One word write; starts on an edge so no signal is driven twice in a step
  task automatic write_reg(input logic [CSR_ADDR_W-1:0] addr, input logic [31:0] data,
                           output logic [1:0] resp);
    logic aw_left;
    logic w_left;
    aw_left = 1'b1;
    w_left  = 1'b1;
    @(posedge core_clk_i);
    awaddr_o  <= addr;
    wdata_o   <= (addr == CMD_STATUS_OFF) ? (data & 32'h0003_000f) : data;
    wstrb_o   <= 4'hf;
    awvalid_o <= 1'b1;
    wvalid_o  <= 1'b1;
    bready_o  <= 1'b1;
    while (aw_left || w_left)
    begin
      @(posedge core_clk_i);
      if (aw_left && awready_i)
      begin
        aw_left = 1'b0;
        awvalid_o <= 1'b0;
      end
      if (w_left && wready_i)
      begin
        w_left = 1'b0;
        wvalid_o <= 1'b0;
      end
    end
    while (!bvalid_i)
      @(posedge core_clk_i);
    resp = bresp_i;
    bready_o <= 1'b0;
  endtask : write_reg

  // One word read; data taken at the edge that sees rvalid
  task automatic read_reg(input logic [CSR_ADDR_W-1:0] addr, output logic [31:0] data,
                          output logic [1:0] resp);
    @(posedge core_clk_i);
    araddr_o  <= addr;
    arvalid_o <= 1'b1;
    rready_o  <= 1'b1;
    do
      @(posedge core_clk_i);
    while (!arready_i);
    arvalid_o <= 1'b0;
    while (!rvalid_i)
      @(posedge core_clk_i);
    data = rdata_i;
    resp = rresp_i;
    rready_o <= 1'b0;
  endtask : read_reg
endmodule : host_driver_model
`default_nettype wire

// ===== testbench/ohci_command_status_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ohci_command_status_logic_tb
  import ohci_cmd_pkg::*;
;
  // Short soft reset keeps the run brief
  localparam int unsigned SR_TB = 8;
  logic                  core_clk;
  logic                  rst_b;
  logic [CSR_ADDR_W-1:0] awaddr, araddr;
  logic [31:0]           wdata, rdata, int_set, model;
  logic [3:0]            wstrb;
  logic [1:0]            bresp, rresp, fstate;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready, routing, sr_busy, hub_rst;
  list_evt_s             evt;
  list_cmd_s             cmd;
  int                    miscompares = 0;
  int                    checked = 0;
  int                    so_pulses = 0;
  int                    oc_pulses = 0;

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  ohci_command_status_logic #(.SOFT_RESET_CYCLES(SR_TB)) dut (
    .core_clk_i(core_clk), .rst_b_i(rst_b), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .list_evt_i(evt), .list_cmd_o(cmd), .int_status_set_o(int_set),
    .functional_state_o(fstate), .interrupt_routing_o(routing),
    .soft_reset_busy_o(sr_busy), .root_hub_reset_o(hub_rst));

  host_driver_model host (
    .core_clk_i(core_clk), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
    .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready),
    .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
    .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp),
    .rvalid_i(rvalid), .rready_o(rready));

  // Count status pulses; one-cycle pulses are easy to miss from a task
  always @(posedge core_clk)
  begin
    if (int_set[IS_SO_BIT] === 1'b1)
      so_pulses++;
    if (int_set[IS_OC_BIT] === 1'b1)
      oc_pulses++;
  end

  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic rd_chk(input logic [CSR_ADDR_W-1:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic [1:0]  r;
    host.read_reg(a, d, r);
    check({what, " resp"}, {30'h0, r}, {30'h0, RESP_OKAY});
    check(what, d, exp);
  endtask : rd_chk

  task automatic wr(input logic [CSR_ADDR_W-1:0] a, input logic [31:0] d);
    logic [1:0] r;
    host.write_reg(a, d, r);
    check("write resp", {30'h0, r}, {30'h0, RESP_OKAY});
  endtask : wr

  // One event pulse, then the answer one cycle later
  task automatic fire(input list_evt_s e, input list_cmd_s exp, input string what);
    @(posedge core_clk);
    evt <= e;
    @(posedge core_clk);
    evt <= '0;
    #1;
    check(what, {28'h0, cmd}, {28'h0, exp});
  endtask : fire

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_reset();
    logic [31:0] d;
    logic [1:0]  r;
    check("root hub reset", {31'h0, hub_rst}, 32'h0);
    check("state", {30'h0, fstate}, {30'h0, FS_RESET});
    check("routing", {31'h0, routing}, 32'h0);
    rd_chk(CMD_STATUS_OFF, CMD_STATUS_RST, "cmd reset");
    host.read_reg(12'h00c, d, r);
    check("stray read resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    host.write_reg(12'h00c, 32'hffff_ffff, r);
    check("stray write resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    rd_chk(CMD_STATUS_OFF, 32'h0, "cmd after stray");
    $display("test reset done");
  endtask : test_reset

  task automatic test_write_set();
    wr(CMD_STATUS_OFF, 32'h2);
    rd_chk(CMD_STATUS_OFF, 32'h2, "set one");
    wr(CMD_STATUS_OFF, 32'h4);
    rd_chk(CMD_STATUS_OFF, 32'h6, "set two");
    wr(CMD_STATUS_OFF, 32'h0);
    rd_chk(CMD_STATUS_OFF, 32'h6, "zero keeps");
    model = 32'h6;
    $display("test write set done");
  endtask : test_write_set

  // Control list first, then bulk list
  task automatic test_lists();
    logic [31:0] b;
    for (int k = 0; k < 2; k++)
    begin
      b = k ? 32'h4 : 32'h2;
      fire(list_evt_s'(k ? 6'h20 : 6'h08), list_cmd_s'(k ? 4'h8 : 4'h2), "go");
      model = model & ~b;
      rd_chk(CMD_STATUS_OFF, model, "filled cleared");
      fire(list_evt_s'(k ? 6'h20 : 6'h08), list_cmd_s'(k ? 4'h4 : 4'h1), "skip");
      fire(list_evt_s'(k ? 6'h10 : 6'h04), '0, "td found");
      model = model | b;
      rd_chk(CMD_STATUS_OFF, model, "filled again");
    end
    $display("test lists done");
  endtask : test_lists

  task automatic test_overrun();
    int n;
    for (int i = 1; i <= 5; i++)
    begin
      n = so_pulses;
      fire(list_evt_s'(6'h02), '0, "overrun");
      @(posedge core_clk);
      #1;
      check("overrun flag", so_pulses - n, 32'h1);
      model = {model[31:18], i[1:0], model[15:0]};
      rd_chk(CMD_STATUS_OFF, model, "overrun count");
    end
    $display("test overrun done");
  endtask : test_overrun

  task automatic test_owner();
    int n;
    n = oc_pulses;
    wr(CMD_STATUS_OFF, 32'h8);
    #1;
    check("owner flag", oc_pulses - n, 32'h1);
    rd_chk(CMD_STATUS_OFF, model | 32'h8, "owner request");
    fire(list_evt_s'(6'h01), '0, "owner done");
    rd_chk(CMD_STATUS_OFF, model, "owner cleared");
    rd_chk(CMD_STATUS_OFF, model, "owner stays");
    $display("test owner done");
  endtask : test_owner

  task automatic test_soft_reset();
    int n;
    wr(CONTROL_OFF, 32'h0000_0180);
    rd_chk(CONTROL_OFF, 32'h0000_0180, "control");
    wr(CMD_STATUS_OFF, 32'h1);
    #1;
    check("busy", {31'h0, sr_busy}, 32'h1);
    check("suspend", {30'h0, fstate}, {30'h0, FS_SUSPEND});
    check("routing kept", {31'h0, routing}, 32'h1);
    check("hub untouched", {31'h0, hub_rst}, 32'h0);
    fire(list_evt_s'(6'h20), list_cmd_s'(4'h4), "start in reset");
    rd_chk(CMD_STATUS_OFF, 32'h1, "cmd in reset");
    n = 0;
    while (sr_busy === 1'b1 && n < 100)
    begin
      @(posedge core_clk);
      n++;
    end
    #1;
    check("reset ends in time", {31'h0, n <= SR_TB}, 32'h1);
    rd_chk(CMD_STATUS_OFF, 32'h0, "cmd after reset");
    check("routing after", {31'h0, routing}, 32'h1);
    $display("test soft reset done");
  endtask : test_soft_reset

  task automatic final_report();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial
  begin
    rst_b = 1'b0;
    evt = '0;
    model = '0;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    #1;
    test_reset();
    test_write_set();
    test_lists();
    test_overrun();
    test_owner();
    test_soft_reset();
    final_report();
  end

  // Tests need well under a thousand cycles; a hang ends here
  initial
  begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    $display("watchdog expired");
    final_report();
  end
endmodule : ohci_command_status_logic_tb
`default_nettype wire
